// *** include/kbce_pkg.sv ***
// Constants, encodings and state types for the keyboard cursor entry control.
// Assumes one 100 MHz clock and key inputs already debounced and synchronous.
// Operation
// - One code per key press, sent to host.
// - Shift selects upper symbol when key has one.
// - Cursor moves only with buffer, generator, keyboard.
// - Cursor steps forward after each entered character.
// - Backspace steps cursor back, text unchanged.
// - Entry overwrites stored character, then cursor advances.
// - Advance steps cursor forward, text unchanged.
// - Space bar enters blank like any character.
// - Repeat key re-fires entry or step while held.
// - Cursor confined to unprotected area; graphics protected.
// - At area end cursor stays; entries overwrite there.
// - Jump goes to next unprotected area start.
// - Single whole-display area: jump goes to first position.
// - Chord with 1, 5, 0 gives null, end, cancel.
// - Null removes character from visible text.
// - Null with repeat keeps consuming following text.
// - Nulls stay stored; cursor hidden on null.
// - No buffer: press raises attention; host reads inputs.
// - Read runs three service cycles; code and flags.
// - Load counter 0,1,2; at 2 release and end.
// - Null is code zero through normal entry path.
// - Entry only at cursor in unprotected position.
package kbce_pkg;

   localparam int              CLK_MHZ        = 100;
   localparam int              REPEAT_MS      = 50;
   localparam int              REPEAT_CYCLES  = REPEAT_MS * 1000 * CLK_MHZ;
   localparam int              REP_W          = 24;

   localparam int              ADDR_W         = 6;
   localparam int              DEPTH          = 64;
   localparam int              CODE_W         = 8;

   localparam logic [5:0]      LAST_POS       = 6'h3f;
   localparam logic [5:0]      FIRST_POS      = 6'h00;
   localparam logic [5:0]      CURSOR_RST     = 6'h00;

   localparam logic [7:0]      NULL_CODE      = 8'h00;
   localparam logic [7:0]      DIGIT1_CODE    = 8'h31;
   localparam logic [7:0]      DIGIT5_CODE    = 8'h35;
   localparam logic [7:0]      DIGIT0_CODE    = 8'h30;
   localparam logic [7:0]      END_CODE       = 8'h01;
   localparam logic [7:0]      CANCEL_CODE    = 8'h02;
   localparam logic [7:0]      CODE_RST       = 8'h00;

   localparam logic [1:0]      LOAD_FIRST     = 2'h0;
   localparam logic [1:0]      LOAD_SECOND    = 2'h1;
   localparam logic [1:0]      LOAD_LAST      = 2'h2;

   typedef enum logic [1:0] {
      KBCE_ACT_CHAR = 2'b00,
      KBCE_ACT_BACK = 2'b01,
      KBCE_ACT_ADV  = 2'b10,
      KBCE_ACT_JUMP = 2'b11
   } kbce_act_t;

   typedef enum logic [1:0] {
      KBCE_SVC_IDLE = 2'b00,
      KBCE_SVC_ATTN = 2'b01,
      KBCE_SVC_RUN  = 2'b10,
      KBCE_SVC_END  = 2'b11
   } kbce_svc_t;

endpackage

// *** src/kbce_top.sv ***
// Keyboard code generation, cursor movement over a small character buffer,
// and the unbuffered attention / service-cycle read toward the channel.
// Assumes key levels stay high while held and channel strobes are one cycle.
`timescale 1ns/1ns
`default_nettype none

module kbce_top #(
   parameter int REPEAT_CYCLES = kbce_pkg::REPEAT_CYCLES
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire logic                        has_buffer,
   input  wire logic                        has_chargen,
   input  wire logic                        has_keyboard,
   input  wire logic                        key_down,
   input  wire logic [kbce_pkg::CODE_W-1:0] key_base_code,
   input  wire logic [kbce_pkg::CODE_W-1:0] key_upper_code,
   input  wire logic                        key_has_upper,
   input  wire logic                        shift_key,
   input  wire logic                        chord_modifier_key,
   input  wire logic                        repeat_key,
   input  wire logic                        backspace_key,
   input  wire logic                        advance_key,
   input  wire logic                        jump_key,
   input  wire logic                        buf_wr_en,
   input  wire logic [kbce_pkg::ADDR_W-1:0] buf_wr_addr,
   input  wire logic [kbce_pkg::CODE_W-1:0] buf_wr_data,
   input  wire logic                        buf_wr_prot,
   input  wire logic                        buf_wr_graphic,
   input  wire logic [kbce_pkg::ADDR_W-1:0] disp_addr,
   output logic      [kbce_pkg::CODE_W-1:0] disp_char,
   output logic                             disp_visible,
   output logic                             disp_cursor,
   output logic      [kbce_pkg::ADDR_W-1:0] cursor_pos,
   output logic                             host_strobe,
   output logic      [kbce_pkg::CODE_W-1:0] host_code,
   output logic                             attention,
   input  wire logic                        read_cmd,
   output logic                             svc_valid,
   input  wire logic                        svc_ack,
   output logic      [1:0]                  svc_count,
   output logic      [kbce_pkg::CODE_W-1:0] svc_data,
   output logic                             svc_end_flag,
   output logic                             svc_cancel_flag,
   output logic                             ending
);

   logic [kbce_pkg::CODE_W-1:0] char_mem [kbce_pkg::DEPTH];
   logic                        prot_mem [kbce_pkg::DEPTH];
   logic                        gfx_mem  [kbce_pkg::DEPTH];

   logic [kbce_pkg::ADDR_W-1:0] cursor_q;
   logic [kbce_pkg::ADDR_W-1:0] fwd_pos;
   logic [kbce_pkg::ADDR_W-1:0] back_pos;
   logic [kbce_pkg::ADDR_W-1:0] jump_pos;
   logic                        jump_found;

   logic                        held_q;
   logic                        lock_q;
   kbce_pkg::kbce_act_t         act_q;
   kbce_pkg::kbce_act_t         act_now;
   kbce_pkg::kbce_act_t         fire_act;
   logic [kbce_pkg::CODE_W-1:0] code_q;
   logic [kbce_pkg::CODE_W-1:0] code_now;
   logic [kbce_pkg::CODE_W-1:0] fire_code;
   logic                        end_now;
   logic                        cancel_now;
   logic                        end_q;
   logic                        cancel_q;
   logic [kbce_pkg::REP_W-1:0]  rep_cnt_q;
   logic                        rep_tick;
   logic                        any_key;
   logic                        press;
   logic                        fire;
   logic                        cursor_en;
   logic                        entry_ok;
   logic                        is_func;

   kbce_pkg::kbce_svc_t         svc_q;
   kbce_pkg::kbce_svc_t         svc_d;
   logic [1:0]                  cnt_q;
   logic [1:0]                  cnt_d;

   // Position counts as unprotected only if neither protection source is set
   function automatic logic open_at(input logic [kbce_pkg::ADDR_W-1:0] a);
      open_at = !prot_mem[a] && !gfx_mem[a];
   endfunction

   assign cursor_en = has_buffer && has_chargen && has_keyboard;
   assign any_key   = key_down || backspace_key || advance_key || jump_key;
   assign press     = any_key && !held_q && !lock_q;

   // Key code: shift, then chord substitutions
   always_comb begin
      code_now   = (shift_key && key_has_upper) ? key_upper_code : key_base_code;
      end_now    = 1'b0;
      cancel_now = 1'b0;
      if (chord_modifier_key && !shift_key) begin
         if (key_base_code == kbce_pkg::DIGIT1_CODE) begin
            code_now = kbce_pkg::NULL_CODE;
         end else if (key_base_code == kbce_pkg::DIGIT5_CODE) begin
            code_now = kbce_pkg::END_CODE;
            end_now  = 1'b1;
         end else if (key_base_code == kbce_pkg::DIGIT0_CODE) begin
            code_now   = kbce_pkg::CANCEL_CODE;
            cancel_now = 1'b1;
         end
      end
   end

   always_comb begin
      if (jump_key) begin
         act_now = kbce_pkg::KBCE_ACT_JUMP;
      end else if (backspace_key) begin
         act_now = kbce_pkg::KBCE_ACT_BACK;
      end else if (advance_key) begin
         act_now = kbce_pkg::KBCE_ACT_ADV;
      end else begin
         act_now = kbce_pkg::KBCE_ACT_CHAR;
      end
   end

   // Held-key tracking and latched code
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         held_q   <= 1'b0;
         act_q    <= kbce_pkg::KBCE_ACT_CHAR;
         code_q   <= kbce_pkg::CODE_RST;
         end_q    <= 1'b0;
         cancel_q <= 1'b0;
      end else begin
         if (press) begin
            held_q   <= 1'b1;
            act_q    <= act_now;
            code_q   <= code_now;
            end_q    <= end_now;
            cancel_q <= cancel_now;
         end else if (!any_key) begin
            held_q <= 1'b0;
         end
      end
   end

   // Repeat rate divider while repeat key and original key are held
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rep_cnt_q <= '0;
      end else if (held_q && any_key && repeat_key && has_buffer
                   && act_q != kbce_pkg::KBCE_ACT_JUMP && !rep_tick) begin
         rep_cnt_q <= rep_cnt_q + 1'b1;
      end else begin
         rep_cnt_q <= '0;
      end
   end

   assign rep_tick  = held_q && any_key && repeat_key && has_buffer
                      && (rep_cnt_q == kbce_pkg::REP_W'(REPEAT_CYCLES - 1));
   assign fire      = (press && has_buffer) || rep_tick;
   assign fire_act  = press ? act_now : act_q;
   assign fire_code = press ? code_now : code_q;
   assign is_func   = press ? (end_now || cancel_now) : (end_q || cancel_q);
   assign entry_ok  = cursor_en && open_at(cursor_q);

   // Cursor neighbours within the current area
   always_comb begin
      fwd_pos  = cursor_q;
      back_pos = cursor_q;
      if (cursor_q != kbce_pkg::LAST_POS && open_at(cursor_q + 1'b1)) begin
         fwd_pos = cursor_q + 1'b1;
      end
      if (cursor_q != kbce_pkg::FIRST_POS && open_at(cursor_q - 1'b1)) begin
         back_pos = cursor_q - 1'b1;
      end
   end

   // First start of an unprotected area after the cursor, wrapping round
   always_comb begin
      logic [kbce_pkg::ADDR_W-1:0] p;
      p          = '0;
      jump_pos   = cursor_q;
      jump_found = 1'b0;
      for (int k = 1; k <= kbce_pkg::DEPTH; k++) begin
         p = cursor_q + kbce_pkg::ADDR_W'(k);
         if (!jump_found && open_at(p)
             && (p == kbce_pkg::FIRST_POS || !open_at(p - 1'b1))) begin
            jump_pos   = p;
            jump_found = 1'b1;
         end
      end
   end

   // Cursor position
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cursor_q <= kbce_pkg::CURSOR_RST;
      end else if (fire && cursor_en) begin
         unique case (fire_act)
            kbce_pkg::KBCE_ACT_BACK: cursor_q <= back_pos;
            kbce_pkg::KBCE_ACT_ADV:  cursor_q <= fwd_pos;
            kbce_pkg::KBCE_ACT_JUMP: cursor_q <= jump_pos;
            kbce_pkg::KBCE_ACT_CHAR: begin
               if (entry_ok && !is_func) begin
                  cursor_q <= fwd_pos;
               end
            end
         endcase
      end
   end

   // Character buffer; keyboard entry wins over the load port
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < kbce_pkg::DEPTH; i++) begin
            char_mem[i] <= kbce_pkg::CODE_RST;
            prot_mem[i] <= 1'b0;
            gfx_mem[i]  <= 1'b0;
         end
      end else begin
         if (buf_wr_en) begin
            char_mem[buf_wr_addr] <= buf_wr_data;
            prot_mem[buf_wr_addr] <= buf_wr_prot;
            gfx_mem[buf_wr_addr]  <= buf_wr_graphic;
         end
         if (fire && fire_act == kbce_pkg::KBCE_ACT_CHAR && entry_ok && !is_func) begin
            char_mem[cursor_q] <= fire_code;
         end
      end
   end

   // Display read port; nulls vanish and hide the cursor
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         disp_char    <= kbce_pkg::CODE_RST;
         disp_visible <= 1'b0;
         disp_cursor  <= 1'b0;
         cursor_pos   <= kbce_pkg::CURSOR_RST;
      end else begin
         disp_char    <= char_mem[disp_addr];
         disp_visible <= char_mem[disp_addr] != kbce_pkg::NULL_CODE;
         disp_cursor  <= cursor_en && disp_addr == cursor_q
                         && char_mem[disp_addr] != kbce_pkg::NULL_CODE;
         cursor_pos   <= cursor_q;
      end
   end

   // Buffered path: every entry goes to host storage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_strobe <= 1'b0;
         host_code   <= kbce_pkg::CODE_RST;
      end else begin
         host_strobe <= fire && fire_act == kbce_pkg::KBCE_ACT_CHAR;
         if (fire && fire_act == kbce_pkg::KBCE_ACT_CHAR) begin
            host_code <= fire_code;
         end
      end
   end

   // Unbuffered attention and service-cycle sequence
   always_comb begin
      svc_d = svc_q;
      cnt_d = cnt_q;
      unique case (svc_q)
         kbce_pkg::KBCE_SVC_IDLE: begin
            if (press && !has_buffer && key_down) begin
               svc_d = kbce_pkg::KBCE_SVC_ATTN;
            end
         end
         kbce_pkg::KBCE_SVC_ATTN: begin
            if (read_cmd) begin
               svc_d = kbce_pkg::KBCE_SVC_RUN;
               cnt_d = kbce_pkg::LOAD_FIRST;
            end
         end
         kbce_pkg::KBCE_SVC_RUN: begin
            if (svc_ack) begin
               if (cnt_q == kbce_pkg::LOAD_LAST) begin
                  svc_d = kbce_pkg::KBCE_SVC_END;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         kbce_pkg::KBCE_SVC_END: begin
            svc_d = kbce_pkg::KBCE_SVC_IDLE;
            cnt_d = kbce_pkg::LOAD_FIRST;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         svc_q <= kbce_pkg::KBCE_SVC_IDLE;
         cnt_q <= kbce_pkg::LOAD_FIRST;
      end else begin
         svc_q <= svc_d;
         cnt_q <= cnt_d;
      end
   end

   // Keyboard held off from press until the last service cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_q <= 1'b0;
      end else if (svc_q == kbce_pkg::KBCE_SVC_IDLE && svc_d == kbce_pkg::KBCE_SVC_ATTN) begin
         lock_q <= 1'b1;
      end else if (svc_d == kbce_pkg::KBCE_SVC_END) begin
         lock_q <= 1'b0;
      end
   end

   // Service data per load count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         svc_data        <= kbce_pkg::CODE_RST;
         svc_end_flag    <= 1'b0;
         svc_cancel_flag <= 1'b0;
         svc_count       <= kbce_pkg::LOAD_FIRST;
         ending          <= 1'b0;
      end else begin
         svc_count       <= cnt_d;
         ending          <= svc_d == kbce_pkg::KBCE_SVC_END;
         svc_data        <= kbce_pkg::CODE_RST;
         svc_end_flag    <= 1'b0;
         svc_cancel_flag <= 1'b0;
         if (svc_d == kbce_pkg::KBCE_SVC_RUN) begin
            if (cnt_d == kbce_pkg::LOAD_FIRST) begin
               svc_data        <= code_q;
               svc_end_flag    <= end_q;
               svc_cancel_flag <= cancel_q;
            end else if (cnt_d == kbce_pkg::LOAD_SECOND) begin
               svc_data <= code_q;
            end
         end
      end
   end

   assign attention = svc_q == kbce_pkg::KBCE_SVC_ATTN;
   assign svc_valid = svc_q == kbce_pkg::KBCE_SVC_RUN;

endmodule // kbce_top

`default_nettype wire

// *** verification/kbce_top_properties.sv ***
// Port assertions for the keyboard cursor entry control.
// Assumes straps change only with no key held and the channel idle.
`timescale 1ns/1ns
`default_nettype none

module kbce_top_properties (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       has_buffer,
   input wire logic       has_chargen,
   input wire logic [5:0] cursor_pos,
   input wire logic       disp_visible,
   input wire logic       disp_cursor,
   input wire logic       host_strobe,
   input wire logic       attention,
   input wire logic       read_cmd,
   input wire logic       svc_valid,
   input wire logic       svc_ack,
   input wire logic [1:0] svc_count,
   input wire logic [7:0] svc_data,
   input wire logic       ending
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   AST_STROBE_PULSE: assert property (host_strobe |=> !host_strobe)
      else $error("host strobe wider than one cycle");
   AST_STROBE_BUF: assert property (host_strobe |-> $past(has_buffer))
      else $error("host strobe without buffer");
   AST_ATTN_UNBUF: assert property ($rose(attention) |-> !has_buffer)
      else $error("attention raised with buffer fitted");
   AST_CURSOR_GATE: assert property (!has_chargen ##1 !has_chargen |=> $stable(cursor_pos))
      else $error("cursor moved without full feature set");
   AST_READ_START: assert property (attention && read_cmd |=> svc_valid && svc_count == 2'h0)
      else $error("read did not start at count zero");
   AST_COUNT_STEP: assert property (svc_valid && svc_ack && svc_count != 2'h2 |=>
      svc_valid && svc_count == $past(svc_count) + 2'h1)
      else $error("load count did not step");
   AST_COUNT_END: assert property (svc_valid && svc_ack && svc_count == 2'h2 |=>
      ending && !svc_valid ##1 !ending)
      else $error("no single ending after count two");
   AST_HOLD_DATA: assert property (svc_valid && !svc_ack |=> svc_valid && $stable(svc_data))
      else $error("service data not held");
   AST_CURSOR_HIDDEN: assert property (disp_cursor |-> disp_visible)
      else $error("cursor shown on null");
endmodule // kbce_top_properties

bind kbce_top kbce_top_properties kbce_top_properties_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .has_buffer(has_buffer), .has_chargen(has_chargen),
   .cursor_pos(cursor_pos), .disp_visible(disp_visible), .disp_cursor(disp_cursor),
   .host_strobe(host_strobe), .attention(attention), .read_cmd(read_cmd),
   .svc_valid(svc_valid), .svc_ack(svc_ack), .svc_count(svc_count), .svc_data(svc_data),
   .ending(ending)
);
`default_nettype wire

// *** verification/kbce_chan_model.sv ***
// Channel partner: answers attention with a manual-input read, fast or slow.
// Assumes one clock shared with the block.
`timescale 1ns/1ns
`default_nettype none

module kbce_chan_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       slow,
   input  wire logic       attention,
   input  wire logic [1:0] svc_count,
   input  wire logic [7:0] svc_data,
   input  wire logic       svc_end_flag,
   input  wire logic       svc_cancel_flag,
   output logic            read_cmd,
   output logic            svc_ack,
   output logic [7:0]      got_first,
   output logic [7:0]      got_second,
   output logic [1:0]      got_flags,
   output logic            got_done
);
   initial begin
      read_cmd = 1'b0;
      svc_ack = 1'b0;
      got_done = 1'b0;
      forever begin
         @(posedge ref_clk);
         got_done <= 1'b0;
         if (rst_n && attention) begin
            repeat (slow ? 3 : 0) @(posedge ref_clk);
            read_cmd <= 1'b1;
            @(posedge ref_clk);
            read_cmd <= 1'b0;
            for (int k = 0; k < 3; k++) begin
               if (slow) repeat (2) @(posedge ref_clk);
               svc_ack <= 1'b1;
               @(posedge ref_clk);
               if (svc_count == 2'h0) {got_first, got_flags} <= {svc_data, svc_end_flag, svc_cancel_flag};
               if (svc_count == 2'h1) got_second <= svc_data;
               if (slow || k == 2) svc_ack <= 1'b0;
            end
            @(posedge ref_clk);
            got_done <= 1'b1;
         end
      end
   end
endmodule // kbce_chan_model
`default_nettype wire

// *** verification/test_keyboard_cursor_entry_control.sv ***
// Bench: entry, cursor moves, areas, repeat, chords and channel reads.
// Assumes the channel model completes every read it starts.
`timescale 1ns/1ns
`default_nettype none

module test_keyboard_cursor_entry_control;
   logic       ref_clk = 1'b0, rst_n = 1'b0, has_buffer = 1'b1, has_chargen = 1'b1, slow = 1'b0;
   logic       key_down = 1'b0, key_has_upper = 1'b0, shift_key = 1'b0, chord_modifier_key = 1'b0;
   logic       repeat_key = 1'b0, backspace_key = 1'b0, advance_key = 1'b0, jump_key = 1'b0;
   logic       buf_wr_en = 1'b0, buf_wr_prot = 1'b0, buf_wr_graphic = 1'b0, has_keyboard = 1'b1;
   logic [7:0] key_base_code = 8'h00, key_upper_code = 8'h00, buf_wr_data = 8'h00;
   logic [5:0] buf_wr_addr = 6'h00, disp_addr = 6'h00, cursor_pos, cur = 6'h00;
   logic [7:0] disp_char, host_code, svc_data, got_first, got_second, k, c;
   logic       disp_visible, disp_cursor, host_strobe, attention, read_cmd, svc_valid, svc_ack;
   logic       svc_end_flag, svc_cancel_flag, ending, got_done;
   logic [1:0] svc_count, got_flags;
   logic [7:0] mem [64] = '{default: 8'h00};
   logic       prot [64] = '{default: 1'b0};
   logic [7:0] chord_keys [3] = '{kbce_pkg::DIGIT1_CODE, kbce_pkg::DIGIT5_CODE, kbce_pkg::DIGIT0_CODE};
   logic [31:0] rv;
   int         seed = 56, bad_count = 0, checks_done = 0, strobes = 0, hits, n, w;

   kbce_top #(.REPEAT_CYCLES(8)) kbce_top_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .has_buffer(has_buffer), .has_chargen(has_chargen),
      .has_keyboard(has_keyboard), .key_down(key_down), .key_base_code(key_base_code),
      .key_upper_code(key_upper_code), .key_has_upper(key_has_upper), .shift_key(shift_key),
      .chord_modifier_key(chord_modifier_key), .repeat_key(repeat_key),
      .backspace_key(backspace_key), .advance_key(advance_key), .jump_key(jump_key),
      .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data),
      .buf_wr_prot(buf_wr_prot), .buf_wr_graphic(buf_wr_graphic), .disp_addr(disp_addr),
      .disp_char(disp_char), .disp_visible(disp_visible), .disp_cursor(disp_cursor),
      .cursor_pos(cursor_pos), .host_strobe(host_strobe), .host_code(host_code),
      .attention(attention), .read_cmd(read_cmd), .svc_valid(svc_valid), .svc_ack(svc_ack),
      .svc_count(svc_count), .svc_data(svc_data), .svc_end_flag(svc_end_flag),
      .svc_cancel_flag(svc_cancel_flag), .ending(ending));
   kbce_chan_model kbce_chan_model_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .attention(attention),
      .svc_count(svc_count), .svc_data(svc_data), .svc_end_flag(svc_end_flag),
      .svc_cancel_flag(svc_cancel_flag), .read_cmd(read_cmd), .svc_ack(svc_ack),
      .got_first(got_first), .got_second(got_second), .got_flags(got_flags),
      .got_done(got_done));

   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (host_strobe === 1'b1) strobes++;

   function automatic logic [7:0] exp_code(logic [7:0] b, logic [7:0] u, logic hu, logic sh,
                                           logic ch);
      if (ch && !sh && b == kbce_pkg::DIGIT1_CODE) return kbce_pkg::NULL_CODE;
      if (ch && !sh && b == kbce_pkg::DIGIT5_CODE) return kbce_pkg::END_CODE;
      if (ch && !sh && b == kbce_pkg::DIGIT0_CODE) return kbce_pkg::CANCEL_CODE;
      return (sh && hu) ? u : b;
   endfunction
   function automatic logic [5:0] step(logic [5:0] p, int d);
      logic [5:0] q;
      q = p + 6'(d);
      if ((d > 0 && p == kbce_pkg::LAST_POS) || (d < 0 && p == kbce_pkg::FIRST_POS) || prot[q])
         return p;
      return q;
   endfunction
   function automatic logic [5:0] jump_to(logic [5:0] p);
      logic [5:0] q;
      for (int i = 1; i < 64; i++) begin
         q = p + 6'(i);
         if (!prot[q] && (q == 6'h00 || prot[q - 6'h01])) return q;
      end
      return p;
   endfunction

   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic press_key(logic [7:0] b, logic [7:0] u, logic hu, logic sh, logic ch);
      logic [7:0] e;
      e = exp_code(b, u, hu, sh, ch);
      @(posedge ref_clk);
      {key_base_code, key_upper_code, key_has_upper, shift_key, chord_modifier_key, key_down} <=
         {b, u, hu, sh, ch, 1'b1};
      @(posedge ref_clk);
      key_down <= 1'b0;
      #1;
      if (has_buffer) begin
         chk("strobe", 8'h01, {7'h00, host_strobe});
         chk("host code", e, host_code);
         if (!(ch && !sh && (b == kbce_pkg::DIGIT5_CODE || b == kbce_pkg::DIGIT0_CODE))
             && !prot[cur]) begin
            mem[cur] = e;
            cur = step(cur, 1);
         end
      end
      repeat (2) @(posedge ref_clk);
      #1;
      chk("cursor", {2'b00, cur}, {2'b00, cursor_pos});
   endtask
   task automatic press_fn(int f);
      @(posedge ref_clk);
      {backspace_key, advance_key, jump_key} <= 3'b100 >> f;
      @(posedge ref_clk);
      {backspace_key, advance_key, jump_key} <= 3'b000;
      if (has_chargen && has_keyboard) cur = (f == 2) ? jump_to(cur) : step(cur, f == 0 ? -1 : 1);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("cursor", {2'b00, cur}, {2'b00, cursor_pos});
   endtask
   task automatic peek(logic [5:0] a);
      @(posedge ref_clk);
      disp_addr <= a;
      @(posedge ref_clk);
      #1;
      chk("char", mem[a], disp_char);
      chk("visible", {7'h00, mem[a] != 8'h00}, {7'h00, disp_visible});
      chk("cursor mark", {7'h00, a == cur && mem[a] != 8'h00}, {7'h00, disp_cursor});
   endtask
   task automatic load(logic [5:0] a, logic p);
      @(posedge ref_clk);
      {buf_wr_en, buf_wr_addr, buf_wr_data, buf_wr_prot, buf_wr_graphic} <=
         {1'b1, a, 8'h2d, p & a[0], p & !a[0]};
      @(posedge ref_clk);
      buf_wr_en <= 1'b0;
      mem[a] = 8'h2d;
      prot[a] = p;
   endtask
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      bad_count++;
      complete_run();
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (n = 0; n < 24; n++) begin
         rv = $random(seed);
         press_key(n == 5 ? 8'h20 : rv[7:0], rv[15:8], rv[16], rv[17], 1'b0);
      end
      repeat (4) press_fn(0);
      press_key(8'h45, 8'h65, 1'b1, 1'b1, 1'b0);
      press_fn(1);
      for (n = 0; n < 3; n++) press_key(chord_keys[n], 8'h21, 1'b1, 1'b0, 1'b1);
      press_fn(0);
      peek(cur);
      @(posedge ref_clk);
      {key_base_code, shift_key, chord_modifier_key, repeat_key, key_down} <=
         {chord_keys[0], 4'b0111};
      w = strobes;
      repeat (30) @(posedge ref_clk);
      {repeat_key, key_down} <= 2'b00;
      repeat (3) @(posedge ref_clk);
      #1;
      hits = strobes - w;
      chk("repeat hits", 8'h01, {7'h00, hits >= 3 && hits <= 4});
      repeat (hits) begin
         mem[cur] = 8'h00;
         cur = step(cur, 1);
      end
      chk("cursor", {2'b00, cur}, {2'b00, cursor_pos});
      for (n = 0; n < 40; n++) peek(n[5:0]);
      load(6'h28, 1'b1);
      load(6'h33, 1'b1);
      repeat (4) press_fn(2);
      for (n = 0; n < 12; n++) press_key(8'h41 + n[7:0], 8'h00, 1'b0, 1'b0, 1'b0);
      press_fn(1);
      peek(6'h32);
      peek(6'h28);
      load(6'h28, 1'b0);
      load(6'h33, 1'b0);
      press_fn(2);
      @(posedge ref_clk);
      has_chargen <= 1'b0;
      press_fn(1);
      @(posedge ref_clk);
      {has_chargen, has_keyboard} <= 2'b10;
      press_fn(1);
      @(posedge ref_clk);
      {has_keyboard, has_buffer} <= 2'b10;
      for (n = 0; n < 6; n++) begin
         rv = $random(seed);
         slow <= (n > 3) ? rv[0] : n[0];
         k = (n < 3) ? chord_keys[n] : rv[15:8];
         press_key(k, rv[23:16], rv[24], 1'b0, n < 3);
         for (w = 0; w < 60 && got_done !== 1'b1; w++) begin
            @(posedge ref_clk);
            #1;
         end
         c = exp_code(k, rv[23:16], rv[24], 1'b0, n < 3);
         chk("read done", 8'h01, {7'h00, got_done});
         chk("first cycle", c, got_first);
         chk("second cycle", c, got_second);
         chk("flags", {6'h00, c == kbce_pkg::END_CODE, c == kbce_pkg::CANCEL_CODE},
             {6'h00, got_flags});
      end
      complete_run();
   end
endmodule // test_keyboard_cursor_entry_control
`default_nettype wire
